// ### ubu_pkg.sv
package ubu_pkg;

  localparam int CELL_BYTES = 53;
  localparam int FIFO_DEPTH = 2;
  localparam int UTOPIA_DIV = 16;
  localparam int BYTE_CYCLES = 16;
  localparam int CLK_MHZ = 250;

  // address map: high byte selects the range, low byte the register
  localparam logic [7:0] PAGE_BRIDGE = 8'h00;
  localparam logic [7:0] PAGE_MGMT = 8'h01;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD_ADDR = 8'h01;
  localparam logic [7:0] OFF_CMD_DATA = 8'h02;
  localparam logic [7:0] OFF_CMD = 8'h03;
  localparam logic [7:0] OFF_RESULT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h05;
  localparam logic [7:0] OFF_MASK = 8'h06;

  localparam int CTRL_EN = 0;
  localparam int CMD_RD = 0;
  localparam int CMD_WR = 1;
  localparam int ST_RD_DONE = 0;
  localparam int ST_WR_DONE = 1;
  localparam int ST_RX_CELL = 2;
  localparam int ST_TX_CELL = 3;
  localparam int ST_RX_OVF = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_W = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [ST_W-1:0] MASK_RST = 5'h00;

  // phases of one USB controller byte access
  localparam logic [3:0] PH_AWR_LO = 4'h1;
  localparam logic [3:0] PH_AWR_HI = 4'h3;
  localparam logic [3:0] PH_DATA = 4'h5;
  localparam logic [3:0] PH_STB_LO = 4'h6;
  localparam logic [3:0] PH_STB_HI = 4'hA;
  localparam logic [3:0] PH_SAMPLE = 4'hB;
  localparam logic [3:0] PH_LAST = 4'(BYTE_CYCLES - 1);

  typedef struct packed {
    logic soc;
    logic [7:0] data;
  } ubu_ent_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic a0;
    logic ctl_oe;
    logic d_oe;
    logic [7:0] d_o;
  } ubu_usb_t;

  typedef enum logic [1:0] {
    US_IDLE = 2'b00,
    US_RX = 2'b01,
    US_TX = 2'b10,
    US_MCU = 2'b11
  } ubu_us_t;

  typedef enum logic [1:0] {
    UR_POLL = 2'b00,
    UR_WAIT = 2'b01,
    UR_XFER = 2'b10
  } ubu_ur_t;

  typedef enum logic [1:0] {
    UT_POLL = 2'b00,
    UT_WAIT = 2'b01,
    UT_FILL = 2'b10,
    UT_XFER = 2'b11
  } ubu_ut_t;

endpackage

// ### ubu_ififo.sv
`timescale 1ns/1ps
`default_nettype none
module ubu_ififo #(
  parameter int DEPTH = ubu_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic push,
  input wire ubu_pkg::ubu_ent_t din,
  input wire logic pop,
  output ubu_pkg::ubu_ent_t dout,
  output logic full,
  output logic empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  ubu_pkg::ubu_ent_t mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign full = (cnt_q == CW'(DEPTH));
  assign empty = (cnt_q == '0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign dout = mem_q[rp_q];

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem_q[wp_q] <= din;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule
`default_nettype wire

// ### ubu_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module ubu_bridge #(
  parameter int CELL_BYTES = ubu_pkg::CELL_BYTES,
  parameter logic [7:0] RX_EP_REG = 8'h20, // arbitrary endpoint register codes
  parameter logic [7:0] TX_EP_REG = 8'h21
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output ubu_pkg::ubu_usb_t usb_bus,
  input wire logic [7:0] usb_d_i,
  output logic utopia_receive_clock,
  input wire logic rx_clav,
  output logic rx_enb_n,
  input wire logic [7:0] rx_data,
  input wire logic rx_soc,
  output logic utopia_transmit_clock,
  input wire logic tx_clav,
  output logic tx_enb_n,
  output logic [7:0] tx_data,
  output logic tx_soc,
  output logic modem_management_port_sel,
  output logic modem_management_port_we,
  output logic [7:0] modem_management_port_addr,
  output logic [7:0] modem_management_port_wdata,
  input wire logic [7:0] modem_management_port_rdata
);
  localparam int DW = $clog2(ubu_pkg::UTOPIA_DIV);
  localparam int CNW = $clog2(CELL_BYTES + 1);
  localparam logic [CNW-1:0] LAST_BYTE = CNW'(CELL_BYTES - 1);
  localparam logic [CNW-1:0] ALL_BYTES = CNW'(CELL_BYTES);

  function automatic logic in_page(input logic [15:0] a, input logic [7:0] p);
    in_page = (a[15:8] == p);
  endfunction

  // ------------------------------------------------------------
  // utopia clock divider
  // ------------------------------------------------------------
  logic [DW-1:0] div_q;
  logic tick;
  logic uclk_q;
  assign tick = (div_q == DW'(ubu_pkg::UTOPIA_DIV - 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // start at the end of a period so the first high phase is full length
      div_q <= DW'(ubu_pkg::UTOPIA_DIV - 1);
      uclk_q <= 1'b0;
    end else begin
      div_q <= div_q + 1'b1;
      uclk_q <= tick || (div_q < DW'(ubu_pkg::UTOPIA_DIV / 2 - 1));
    end
  end
  assign utopia_receive_clock = uclk_q;
  assign utopia_transmit_clock = uclk_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] cmd_addr_q;
  logic [7:0] cmd_data_q;
  logic [7:0] result_q;
  logic [ubu_pkg::ST_W-1:0] status_q;
  logic [ubu_pkg::ST_W-1:0] mask_q;
  logic [ubu_pkg::ST_W-1:0] ev;
  logic [7:0] rdata_q;
  logic irq_q;
  logic mcu_pend_q;
  logic mcu_rd_q;
  logic en;
  logic br_wr;
  logic br_rd;
  assign en = ctrl_q[ubu_pkg::CTRL_EN];
  assign br_wr = reg_wr && in_page(reg_addr, ubu_pkg::PAGE_BRIDGE);
  assign br_rd = reg_rd && in_page(reg_addr, ubu_pkg::PAGE_BRIDGE);

  logic [7:0] mg_addr_q;
  logic [7:0] mg_wdata_q;
  logic mg_sel_q;
  logic mg_we_q;

  // the address is held so the management port sees it after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mg_addr_q <= 8'h00;
      mg_wdata_q <= 8'h00;
      mg_sel_q <= 1'b0;
      mg_we_q <= 1'b0;
    end else begin
      mg_sel_q <= (reg_wr || reg_rd) && in_page(reg_addr, ubu_pkg::PAGE_MGMT);
      if ((reg_wr || reg_rd) && in_page(reg_addr, ubu_pkg::PAGE_MGMT)) begin
        mg_addr_q <= reg_addr[7:0];
        mg_we_q <= reg_wr;
        if (reg_wr) begin
          mg_wdata_q <= reg_wdata;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= ubu_pkg::CTRL_RST;
      cmd_addr_q <= 8'h00;
      cmd_data_q <= 8'h00;
      mask_q <= ubu_pkg::MASK_RST;
    end else if (br_wr) begin
      unique case (reg_addr[7:0])
        ubu_pkg::OFF_CTRL: ctrl_q <= reg_wdata;
        ubu_pkg::OFF_CMD_ADDR: cmd_addr_q <= reg_wdata;
        ubu_pkg::OFF_CMD_DATA: cmd_data_q <= reg_wdata;
        ubu_pkg::OFF_MASK: mask_q <= reg_wdata[ubu_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // events win over a write-one-to-clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (br_wr && reg_addr[7:0] == ubu_pkg::OFF_STATUS) begin
        status_q <= (status_q & ~reg_wdata[ubu_pkg::ST_W-1:0]) | ev;
      end else begin
        status_q <= status_q | ev;
      end
      irq_q <= |((status_q | ev) & mask_q);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= 8'h00;
      if (in_page(reg_addr, ubu_pkg::PAGE_MGMT)) begin
        rdata_q <= modem_management_port_rdata;
      end else if (br_rd) begin
        unique case (reg_addr[7:0])
          ubu_pkg::OFF_CTRL: rdata_q <= ctrl_q;
          ubu_pkg::OFF_CMD_ADDR: rdata_q <= cmd_addr_q;
          ubu_pkg::OFF_CMD_DATA: rdata_q <= cmd_data_q;
          ubu_pkg::OFF_RESULT: rdata_q <= result_q;
          ubu_pkg::OFF_STATUS: rdata_q <= {2'b00, mcu_pend_q, status_q};
          ubu_pkg::OFF_MASK: rdata_q <= {3'b000, mask_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // interface fifos
  // ------------------------------------------------------------
  ubu_pkg::ubu_ent_t rxf_din, rxf_dout, txf_din, txf_dout;
  logic rxf_push, rxf_pop, rxf_full, rxf_empty;
  logic txf_push, txf_pop, txf_full, txf_empty;

  ubu_ififo u_rxf (
    .mclk(mclk), .arst_n(arst_n), .push(rxf_push), .din(rxf_din), .pop(rxf_pop),
    .dout(rxf_dout), .full(rxf_full), .empty(rxf_empty)
  );
  ubu_ififo u_txf (
    .mclk(mclk), .arst_n(arst_n), .push(txf_push), .din(txf_din), .pop(txf_pop),
    .dout(txf_dout), .full(txf_full), .empty(txf_empty)
  );

  // ------------------------------------------------------------
  // utopia receive
  // ------------------------------------------------------------
  ubu_pkg::ubu_ur_t ur_q;
  logic [CNW-1:0] ur_cnt_q;
  logic rx_req_q;
  logic rx_ack_q;
  logic rx_enb_q;

  // no per-byte handshake on the PHY: a full fifo here means a lost byte
  assign rxf_push = tick && ur_q == ubu_pkg::UR_XFER && !rxf_full;
  assign rxf_din = '{soc: rx_soc, data: rx_data};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ur_q <= ubu_pkg::UR_POLL;
      ur_cnt_q <= '0;
      rx_req_q <= 1'b0;
      rx_enb_q <= 1'b1;
    end else if (tick) begin
      unique case (ur_q)
        ubu_pkg::UR_POLL: begin
          if (en && rx_clav) begin
            rx_req_q <= 1'b1;
            ur_q <= ubu_pkg::UR_WAIT;
          end
        end
        ubu_pkg::UR_WAIT: begin
          if (rx_ack_q) begin
            rx_req_q <= 1'b0;
            rx_enb_q <= 1'b0;
            ur_cnt_q <= '0;
            ur_q <= ubu_pkg::UR_XFER;
          end
        end
        ubu_pkg::UR_XFER: begin
          ur_cnt_q <= ur_cnt_q + 1'b1;
          if (ur_cnt_q == LAST_BYTE) begin
            rx_enb_q <= 1'b1;
            ur_q <= ubu_pkg::UR_POLL;
          end
        end
        default: ur_q <= ubu_pkg::UR_POLL;
      endcase
    end
  end
  assign rx_enb_n = rx_enb_q;

  // ------------------------------------------------------------
  // utopia transmit
  // ------------------------------------------------------------
  ubu_pkg::ubu_ut_t ut_q;
  logic [CNW-1:0] ut_cnt_q;
  logic tx_req_q;
  logic tx_ack_q;
  logic tx_enb_q;
  logic [7:0] tx_data_q;
  logic tx_soc_q;
  logic tx_done;

  assign txf_pop = tick && ut_q == ubu_pkg::UT_XFER && !txf_empty;
  assign tx_done = txf_pop && ut_cnt_q == LAST_BYTE;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ut_q <= ubu_pkg::UT_POLL;
      ut_cnt_q <= '0;
      tx_req_q <= 1'b0;
      tx_enb_q <= 1'b1;
      tx_data_q <= 8'h00;
      tx_soc_q <= 1'b0;
    end else if (tick) begin
      tx_enb_q <= !txf_pop;
      if (txf_pop) begin
        tx_data_q <= txf_dout.data;
        tx_soc_q <= txf_dout.soc;
      end
      unique case (ut_q)
        ubu_pkg::UT_POLL: begin
          if (en && tx_clav) begin
            tx_req_q <= 1'b1;
            ut_q <= ubu_pkg::UT_WAIT;
          end
        end
        ubu_pkg::UT_WAIT: begin
          if (tx_ack_q) begin
            tx_req_q <= 1'b0;
            ut_q <= ubu_pkg::UT_FILL;
          end
        end
        ubu_pkg::UT_FILL: begin
          if (txf_full) begin
            ut_cnt_q <= '0;
            ut_q <= ubu_pkg::UT_XFER;
          end
        end
        ubu_pkg::UT_XFER: begin
          if (txf_pop) begin
            ut_cnt_q <= ut_cnt_q + 1'b1;
          end
          if (tx_done) begin
            ut_q <= ubu_pkg::UT_POLL;
          end
        end
      endcase
    end
  end
  assign tx_enb_n = tx_enb_q;
  assign tx_data = tx_data_q;
  assign tx_soc = tx_soc_q;

  // ------------------------------------------------------------
  // usb controller bus
  // ------------------------------------------------------------
  ubu_pkg::ubu_us_t us_q;
  ubu_pkg::ubu_usb_t pins_q;
  logic [CNW-1:0] us_cnt_q;
  logic act_q;
  logic [3:0] ph_q;
  logic op_rd_q;
  logic [7:0] op_addr_q;
  logic [7:0] op_data_q;
  logic done;
  logic start;
  logic last;
  logic st_rd;
  logic [7:0] st_addr;
  logic [7:0] st_data;
  logic in_stb;

  assign done = act_q && ph_q == ubu_pkg::PH_LAST;
  assign last = done && us_cnt_q == ((us_q == ubu_pkg::US_MCU) ? CNW'(1) : ALL_BYTES);

  // on receive a new byte may start on the closing cycle of the previous one, so
  // received cell bytes flow at exactly one per utopia clock
  always_comb begin
    start = 1'b0;
    st_rd = 1'b0;
    st_addr = RX_EP_REG;
    st_data = rxf_dout.data;
    unique case (us_q)
      ubu_pkg::US_RX: begin
        start = (!act_q || done) && !rxf_empty && us_cnt_q != ALL_BYTES;
      end
      ubu_pkg::US_TX: begin
        start = !act_q && !txf_full && us_cnt_q != ALL_BYTES;
        st_rd = 1'b1;
        st_addr = TX_EP_REG;
      end
      ubu_pkg::US_MCU: begin
        start = !act_q && us_cnt_q == '0;
        st_rd = mcu_rd_q;
        st_addr = cmd_addr_q;
        st_data = cmd_data_q;
      end
      default: start = 1'b0;
    endcase
  end
  assign rxf_pop = start && us_q == ubu_pkg::US_RX;
  assign txf_push = done && us_q == ubu_pkg::US_TX;
  assign txf_din = '{soc: (us_cnt_q == CNW'(1)), data: op_data_q};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      us_q <= ubu_pkg::US_IDLE;
      us_cnt_q <= '0;
      rx_ack_q <= 1'b0;
      tx_ack_q <= 1'b0;
    end else begin
      if (!rx_req_q) begin
        rx_ack_q <= 1'b0;
      end
      if (!tx_req_q) begin
        tx_ack_q <= 1'b0;
      end
      if (start) begin
        us_cnt_q <= us_cnt_q + 1'b1;
      end
      unique case (us_q)
        ubu_pkg::US_IDLE: begin
          us_cnt_q <= '0;
          if (en && rx_req_q) begin
            rx_ack_q <= 1'b1;
            us_q <= ubu_pkg::US_RX;
          end else if (en && tx_req_q) begin
            tx_ack_q <= 1'b1;
            us_q <= ubu_pkg::US_TX;
          end else if (en && mcu_pend_q) begin
            us_q <= ubu_pkg::US_MCU;
          end
        end
        default: begin
          if (last) begin
            us_q <= ubu_pkg::US_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      act_q <= 1'b0;
      ph_q <= 4'h0;
      op_rd_q <= 1'b0;
      op_addr_q <= 8'h00;
      op_data_q <= 8'h00;
    end else if (start) begin
      act_q <= 1'b1;
      ph_q <= 4'h0;
      op_rd_q <= st_rd;
      op_addr_q <= st_addr;
      op_data_q <= st_data;
    end else begin
      if (done) begin
        act_q <= 1'b0;
      end
      if (act_q) begin
        ph_q <= ph_q + 1'b1;
      end
      if (act_q && op_rd_q && ph_q == ubu_pkg::PH_SAMPLE) begin
        op_data_q <= usb_d_i;
      end
    end
  end

  assign in_stb = ph_q >= ubu_pkg::PH_STB_LO && ph_q <= ubu_pkg::PH_STB_HI;

  // while disabled every enable stays low so the controller's pins float
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pins_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a0: 1'b0, ctl_oe: 1'b0,
                  d_oe: 1'b0, d_o: 8'h00};
    end else begin
      pins_q.ctl_oe <= en;
      pins_q.d_oe <= en && act_q && (ph_q < ubu_pkg::PH_DATA || !op_rd_q);
      pins_q.cs_n <= !act_q;
      pins_q.a0 <= act_q && ph_q < ubu_pkg::PH_DATA;
      pins_q.d_o <= (ph_q < ubu_pkg::PH_DATA) ? op_addr_q : op_data_q;
      pins_q.wr_n <= !(act_q && ((ph_q >= ubu_pkg::PH_AWR_LO && ph_q <= ubu_pkg::PH_AWR_HI)
                     || (!op_rd_q && in_stb)));
      pins_q.rd_n <= !(act_q && op_rd_q && in_stb);
    end
  end

  // ------------------------------------------------------------
  // microcontroller command and result
  // ------------------------------------------------------------
  logic mcu_fin;
  assign mcu_fin = done && us_q == ubu_pkg::US_MCU;

  // a command written while one is pending is dropped; software polls busy
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mcu_pend_q <= 1'b0;
      mcu_rd_q <= 1'b0;
      result_q <= 8'h00;
    end else begin
      if (mcu_fin) begin
        mcu_pend_q <= 1'b0;
        if (op_rd_q) begin
          result_q <= op_data_q;
        end
      end else if (!mcu_pend_q && br_wr && reg_addr[7:0] == ubu_pkg::OFF_CMD) begin
        if (reg_wdata[ubu_pkg::CMD_RD] || reg_wdata[ubu_pkg::CMD_WR]) begin
          mcu_pend_q <= 1'b1;
          mcu_rd_q <= reg_wdata[ubu_pkg::CMD_RD];
        end
      end
    end
  end

  always_comb begin
    ev = '0;
    ev[ubu_pkg::ST_RD_DONE] = mcu_fin && op_rd_q;
    ev[ubu_pkg::ST_WR_DONE] = mcu_fin && !op_rd_q;
    ev[ubu_pkg::ST_RX_CELL] = last && us_q == ubu_pkg::US_RX;
    ev[ubu_pkg::ST_TX_CELL] = tick && tx_done;
    ev[ubu_pkg::ST_RX_OVF] = tick && ur_q == ubu_pkg::UR_XFER && rxf_full;
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign usb_bus = pins_q;
  assign modem_management_port_sel = mg_sel_q;
  assign modem_management_port_we = mg_we_q;
  assign modem_management_port_addr = mg_addr_q;
  assign modem_management_port_wdata = mg_wdata_q;
endmodule
`default_nettype wire

// ### ubu_bridge_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// bridge port checks
// ----
module ubu_bridge_assertions (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ubu_pkg::ubu_usb_t usb_bus,
  input wire logic utopia_receive_clock,
  input wire logic utopia_transmit_clock,
  input wire logic rx_enb_n,
  input wire logic tx_enb_n,
  input wire logic tx_soc,
  input wire logic modem_management_port_sel,
  input wire logic [7:0] modem_management_port_addr
);
  logic en_q;
  logic [10:0] rx_len_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) en_q <= 1'b0;
    else if (reg_wr && reg_addr == 16'h0000) en_q <= reg_wdata[0];
  end
  // counts mclk cycles of one receive enable window
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) rx_len_q <= 11'h000;
    else rx_len_q <= rx_enb_n ? 11'h000 : rx_len_q + 11'h001;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_rx_clk_div: assert property ($rose(utopia_receive_clock) |->
    utopia_receive_clock [*8] ##1 !utopia_receive_clock) else $error("rx clock not mclk/16");
  a_enb_on_edge: assert property ($changed({rx_enb_n, tx_enb_n}) |->
    $rose(utopia_receive_clock) && $rose(utopia_transmit_clock))
    else $error("utopia enable moved off a clock edge");
  a_pins_off: assert property (!en_q |-> !usb_bus.ctl_oe && !usb_bus.d_oe)
    else $error("usb pins driven while disabled");
  a_byte_phases: assert property ($fell(usb_bus.cs_n) |-> usb_bus.a0 && usb_bus.d_oe
    ##5 !usb_bus.a0 ##1 !(usb_bus.rd_n && usb_bus.wr_n)) else $error("byte phases wrong");
  a_strobe_len: assert property ($fell(usb_bus.rd_n) |-> !usb_bus.rd_n [*5] ##1 usb_bus.rd_n)
    else $error("read strobe length wrong");
  a_mgmt_sel: assert property (reg_wr && reg_addr[15:8] == 8'h01 |=>
    modem_management_port_sel && modem_management_port_addr == $past(reg_addr[7:0]))
    else $error("management select missing");
  a_sel_cause: assert property (modem_management_port_sel |->
    $past(reg_addr[15:8]) == 8'h01 && ($past(reg_wr) || $past(reg_rd)))
    else $error("stray management select");
  a_tx_soc_byte: assert property (tx_soc |-> !tx_enb_n) else $error("soc without byte");
  a_rx_cell_len: assert property ($rose(rx_enb_n) |->
    rx_len_q >= 11'h340 && rx_len_q <= 11'h360) else $error("rx cell length wrong");
endmodule
bind ubu_bridge ubu_bridge_assertions u_chk (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .usb_bus, .utopia_receive_clock, .utopia_transmit_clock, .rx_enb_n, .tx_enb_n,
  .tx_soc, .modem_management_port_sel, .modem_management_port_addr);
`default_nettype wire

// ### ubu_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// usb controller and utopia phy model
// ----
module ubu_partner (
  input wire logic mclk,
  input wire ubu_pkg::ubu_usb_t usb_bus,
  output logic [7:0] usb_d_i,
  input wire logic utopia_receive_clock,
  input wire logic utopia_transmit_clock,
  output logic rx_clav,
  input wire logic rx_enb_n,
  output logic [7:0] rx_data,
  output logic rx_soc,
  output logic tx_clav,
  input wire logic tx_enb_n,
  input wire logic [7:0] tx_data,
  input wire logic tx_soc,
  input wire logic rx_go,
  input wire logic tx_go
);
  logic [7:0] mem [256];
  logic [7:0] ad, rv, rf, rl, tf, rn, tn, ri, tc;
  logic wq, rq, uq, vq, rg, tg;
  logic [1:0] hold;
  initial begin
    {rn, tc, rv, rx_data, rx_soc, hold, uq, vq, rg, tg} = '0;
    {wq, rq} = 2'b11;
    ri = 8'h35;
    tn = 8'h35;
  end
  // released bus shows the inverse, not a stale byte
  assign usb_d_i = hold != 2'h0 ? rv : ~rv;
  assign rx_clav = ri < 8'h35;
  assign tx_clav = tn < 8'h35;
  always @(posedge mclk) begin
    wq <= usb_bus.wr_n;
    rq <= usb_bus.rd_n;
    hold <= !usb_bus.rd_n ? 2'h2 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
    if (!usb_bus.cs_n && usb_bus.a0 && !usb_bus.wr_n) ad <= usb_bus.d_o;
    if (usb_bus.wr_n && !wq && !usb_bus.a0) begin
      mem[ad] <= usb_bus.d_o;
      if (ad == 8'h20) begin
        rn <= rn + 8'h01;
        rl <= usb_bus.d_o;
        if (rn == 8'h00) rf <= usb_bus.d_o;
      end
    end
    if (!usb_bus.rd_n && rq) begin
      rv <= ad == 8'h21 ? 8'h80 + tc : mem[ad];
      if (ad == 8'h21) tc <= tc + 8'h01;
    end
    // phy acts one mclk after each falling utopia clock, clear of the sampling edge
    uq <= utopia_receive_clock;
    rg <= rx_go;
    if (rx_go && !rg) ri <= 8'h00;
    else if (uq && !utopia_receive_clock) begin
      if (!rx_enb_n && ri < 8'h35) begin
        rx_data <= 8'h40 + ri;
        rx_soc <= ri == 8'h00;
        ri <= ri + 8'h01;
      end else begin
        rx_data <= ~rx_data;
        rx_soc <= 1'b0;
      end
    end
    vq <= utopia_transmit_clock;
    tg <= tx_go;
    if (tx_go && !tg) tn <= 8'h00;
    else if (vq && !utopia_transmit_clock && !tx_enb_n) begin
      if (tx_soc) tf <= tx_data;
      tn <= tx_soc ? 8'h01 : tn + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### ubu_bridge_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// bridge testbench
// ----
module ubu_bridge_tb_top;
  logic mclk, arst_n, reg_wr, reg_rd, irq, rx_go, tx_go, urc, utc, mm_sel, mm_we;
  logic rx_clav, rx_enb_n, rx_soc, tx_clav, tx_enb_n, tx_soc;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, usb_d_i, rx_data, tx_data, mm_addr, mm_wdata, d;
  ubu_pkg::ubu_usb_t usb_bus;
  int failures, check_count;
  ubu_bridge dut (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .usb_bus, .usb_d_i, .utopia_receive_clock(urc), .rx_clav, .rx_enb_n, .rx_data, .rx_soc,
    .utopia_transmit_clock(utc), .tx_clav, .tx_enb_n, .tx_data, .tx_soc,
    .modem_management_port_sel(mm_sel), .modem_management_port_we(mm_we),
    .modem_management_port_addr(mm_addr), .modem_management_port_wdata(mm_wdata),
    .modem_management_port_rdata(8'hA5));
  ubu_partner p (.mclk, .usb_bus, .usb_d_i, .utopia_receive_clock(urc),
    .utopia_transmit_clock(utc), .rx_clav, .rx_enb_n, .rx_data, .rx_soc, .tx_clav, .tx_enb_n,
    .tx_data, .tx_soc, .rx_go, .tx_go);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  // polls status, then clears the bit it waited for
  task wait_st(input int b);
    int n;
    d = 8'h00;
    for (n = 0; n < 800 && d[b] !== 1'b1; n++) rd(16'h0005);
    chk({7'h00, d[b]}, 8'h01);
    wr(16'h0005, 8'h01 << b);
  endtask
  task t_regs;
    rd(16'h0000);
    chk(d, 8'h00);
    rd(16'h0006);
    chk(d, 8'h00);
    rd(16'h0200);
    chk(d, 8'h00);
    wr(16'h0006, 8'h1F);
    rd(16'h0006);
    chk(d, 8'h1F);
  endtask
  task t_mgmt;
    wr(16'h0133, 8'h5C);
    @(negedge mclk);
    chk(mm_wdata, 8'h5C);
    chk({7'h00, mm_we}, 8'h01);
    chk(mm_addr, 8'h33);
    chk({7'h00, mm_sel}, 8'h01);
    rd(16'h0107);
    chk(d, 8'hA5);
  endtask
  task t_mcu;
    wr(16'h0000, 8'h01);
    wr(16'h0001, 8'h07);
    wr(16'h0002, 8'h3C);
    wr(16'h0006, 8'h02);
    wr(16'h0003, 8'h02);
    wait_st(1);
    chk(p.mem[7], 8'h3C);
    repeat (3) @(posedge mclk);
    chk({7'h00, irq}, 8'h00);
    wr(16'h0003, 8'h01);
    wait_st(0);
    rd(16'h0004);
    chk(d, 8'h3C);
    chk({7'h00, irq}, 8'h00);
    wr(16'h0006, 8'h01);
    wr(16'h0003, 8'h01);
    repeat (40) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    wait_st(0);
    repeat (3) @(negedge mclk);
    chk({7'h00, irq}, 8'h00);
  endtask
  task t_rx;
    @(posedge mclk);
    rx_go <= 1'b1;
    wait_st(2);
    rx_go <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(p.rn, 8'h35);
    chk(p.rf, 8'h40);
    chk(p.rl, 8'h74);
  endtask
  task t_tx;
    tx_go <= 1'b1;
    wait_st(3);
    tx_go <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(p.tn, 8'h35);
    chk(p.tf, 8'h80);
  endtask
  task t_prio;
    int n;
    rx_go <= 1'b1;
    for (n = 0; n < 3000 && rx_enb_n; n++) @(posedge mclk);
    wr(16'h0003, 8'h02);
    wait_st(1);
    chk(p.rn, 8'h6A);
    wait_st(2);
    rx_go <= 1'b0;
  endtask
  initial begin
    {arst_n, reg_wr, reg_rd, rx_go, tx_go, reg_addr, reg_wdata} = '0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs;
    t_mgmt;
    t_mcu;
    t_rx;
    t_tx;
    t_prio;
    end_sim;
  end
  // three cells and register traffic need well under this span
  initial begin
    #200000;
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
